/* cpmrc_pkg.sv */
// constants, state encoding and carrier types for the clock, power-mode and reset controller
// assumes one 200 MHz system clock and register access over an ahb-lite slave port

package cpmrc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;                         // system clock rate
  localparam int IRC_START_US = 60;                     // rc oscillator start-up after power-down
  localparam int IRC_START_CYC = IRC_START_US * CLK_MHZ; // least time, whole cycles
  localparam int WAKE_IRC_CYC = 4;                      // rc cycles before resuming
  localparam int WAKE_MAIN_CYC = 4096;                  // crystal cycles before resuming
  localparam int WAKE_RTC_CYC = 4;                      // 32 khz cycles before resuming
  localparam int RST_OSC_CYC = 64;                      // rc cycles counted after reset release
  localparam int LOCK_REFS = 8;                         // matched reference periods for lock
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PLLCFG = 12'h004;
  localparam logic [11:0] ADDR_DIV = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_RSTSRC = 12'h010;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 0;   // 2-bit source select
  localparam int CTRL_PLLE = 2;      // pll active
  localparam int CTRL_PLLC = 3;      // pll connected
  localparam int CTRL_MODE_LSB = 4;  // 2-bit mode request, write only
  localparam int PLL_N_LSB = 0;      // 8-bit pre-divider minus one
  localparam int PLL_M_LSB = 8;      // 15-bit multiplier minus one
  localparam int DIV_PROCESSOR_CLOCK_LSB = 0;   // 8-bit processor divider
  localparam int DIV_USB_LSB = 8;    // 4-bit usb divider
  localparam int ST_LOCK = 0;
  localparam int ST_CONN = 1;
  localparam int ST_STATE_LSB = 2;
  localparam int ST_WSRC_LSB = 8;
  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_IRC = 2'h0;
  localparam logic [1:0] SEL_MAIN = 2'h1;
  localparam logic [1:0] SEL_RTC = 2'h2;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_PDOWN = 2'h3;
  localparam logic [7:0] PLL_N_RST = 8'h00;
  localparam logic [14:0] PLL_M_RST = 15'h0000;

  // gray codes along reset -> run and wake -> run, except power-down -> wake count (two bits); run -> sleep/power-down flips two or three bits
  typedef enum logic [2:0] {
    ST_RST = 3'h0,
    ST_RUN = 3'h1,
    ST_WCNT = 3'h3,
    ST_WSTART = 3'h2,
    ST_PDOWN = 3'h6,
    ST_SLEEP = 3'h7,
    ST_IDLE = 3'h5
  } cpmrc_state_t;

  // raw oscillator levels arriving from the analog cells
  typedef struct packed {
    logic internal_rc_oscillator;
    logic main_osc;
    logic rtc;
    logic current_controlled_oscillator;
  } cpmrc_osc_t;

  // active-high chip reset requests
  typedef struct packed {
    logic wdt;
    logic por;
    logic brownout_detector;
  } cpmrc_rsrc_t;
endpackage

/* cpmrc_ctrl.sv */
// clock source select, pll divider/compare, power-mode sequencer and reset hold for the chip
// assumes oscillator and reset inputs are asynchronous to clk; oscillators run below clk/2
// How it works
// - cpu clock equals input unless pll connected
// - pll input pre-divided by 1 to 256
// - feedback divides cco by 1 to 32768
// - reset and power-down turn pll off
// - software connects pll only once locked
// - rc oscillator after power-up and power-down
// - power-down wake always passes wake timer
// - idle stalls cpu, peripherals keep clocks
// - sleep stops crystal, gates clocks, holds pins
// - sleep gates rc output, rc stays powered
// - 32 khz oscillator keeps running in sleep
// - sleep switches off and disconnects pll
// - sleep zeroes cpu and usb dividers
// - sleep ends on reset or clockless interrupt
// - rc wake from sleep waits 4 cycles
// - crystal wake from sleep waits 4096 cycles
// - power-down adds rc oscillator power-off
// - rc power-down wake: 60 us then 4
// - four sources raise chip reset
// - reset held until pin, oscillator, count
// - registers hold defaults at reset release
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps

module cpmrc_ctrl
  import cpmrc_pkg::*;
#(
  parameter int unsigned IRC_START_CYCLES = IRC_START_CYC,
  parameter int unsigned WAKE_MAIN_CYCLES = WAKE_MAIN_CYC,
  parameter int unsigned RST_OSC_CYCLES = RST_OSC_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire cpmrc_osc_t osc_in,
  input wire cpmrc_rsrc_t rst_src,
  input wire logic ext_rst_n,
  input wire logic irq_wake,
  input wire logic clockless_wake,
  output logic processor_clock,
  output logic usb_clock,
  output logic periph_clk_en,
  output logic cpu_stall,
  output logic chip_rst,
  output logic main_osc_en,
  output logic irc_power_en,
  output logic irc_out_en,
  output logic rtc_osc_en,
  output logic pins_hold,
  output logic pll_bypass,
  output logic cco_up,
  output logic cco_dn
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] a_in; // raw asynchronous inputs
  logic [NSYNC-1:0] s2;   // second-stage outputs, safe to read
  assign a_in = {osc_in, rst_src, ext_rst_n, irq_wake, clockless_wake};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic m; // first stage, read only by q
      logic q;
      // two flops per pin; the pin reset line resets to asserted
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          m <= 1'b0;
          q <= 1'b0;
        end else begin
          m <= a_in[gi];
          q <= m;
        end
      end
      assign s2[gi] = q;
    end
  endgenerate

  cpmrc_osc_t osc_s;    // synchronised oscillator levels
  cpmrc_osc_t osc_d;    // one cycle older
  cpmrc_osc_t osc_rise; // one-cycle pulse per oscillator cycle
  logic any_rst;        // some reset source active
  logic irq_s;          // any interrupt
  logic cl_wake_s;      // interrupt that works without clocks
  assign osc_s = s2[9:6];
  assign osc_rise = osc_s & ~osc_d;
  assign any_rst = s2[5] | s2[4] | s2[3] | ~s2[2];
  assign irq_s = s2[1];
  assign cl_wake_s = s2[0];

  // edge history for the oscillator levels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_d <= '0;
    end else begin
      osc_d <= osc_s;
    end
  end

  // ----------------------------------------------------------------
  // state and shared declarations
  // ----------------------------------------------------------------
  cpmrc_state_t state;       // power-mode sequencer
  logic [13:0] cnt;          // wake and reset counter
  logic [1:0] wake_src;      // source in use when a low-power mode was entered
  logic [1:0] clk_sel;       // selected pll input
  logic pll_en;              // pll active
  logic pll_con;             // pll connected request
  logic [7:0] pll_n;         // pre-divide minus one
  logic [14:0] pll_m;        // multiply minus one
  logic [7:0] processor_clock_div;      // processor divider
  logic [3:0] usb_div;       // usb divider
  logic [3:0] rst_flags;     // sticky reset causes: ext, wdt, por, bod
  logic pll_lock;            // feedback tracks reference
  logic pll_connected;       // effective connection
  logic mode_req;            // one-cycle request from a ctrl write
  logic [1:0] mode_val;
  logic enter_low;           // sleep or power-down entered this cycle
  logic enter_pd;            // power-down entered this cycle
  logic sel_rise;            // cycle of the selected input clock
  logic low_pwr;             // clocks gated

  // only an active, connected, locked pll alters the cpu clock
  assign pll_connected = pll_con & pll_en & pll_lock;
  assign enter_low = (state == ST_RUN) & mode_req & (mode_val[1]);
  assign enter_pd = (state == ST_RUN) & mode_req & (mode_val == MODE_PDOWN);
  assign low_pwr = (state == ST_SLEEP) | (state == ST_PDOWN) | (state == ST_WSTART) | (state == ST_WCNT);

  // pll input select
  always_comb begin
    case (clk_sel)
      SEL_MAIN: sel_rise = osc_rise.main_osc;
      SEL_RTC: sel_rise = osc_rise.rtc;
      default: sel_rise = osc_rise.internal_rc_oscillator;
    endcase
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic take;          // address phase accepted
  logic wr_pend;       // write data phase follows
  logic [11:0] wr_addr;
  logic [31:0] rd_mux;
  assign take = hsel & htrans[1] & hready;

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[11:0])
      ADDR_CTRL: begin
        rd_mux[CTRL_SEL_LSB +: 2] = clk_sel;
        rd_mux[CTRL_PLLE] = pll_en;
        rd_mux[CTRL_PLLC] = pll_con;
      end
      ADDR_PLLCFG: begin
        rd_mux[PLL_N_LSB +: 8] = pll_n;
        rd_mux[PLL_M_LSB +: 15] = pll_m;
      end
      ADDR_DIV: begin
        rd_mux[DIV_PROCESSOR_CLOCK_LSB +: 8] = processor_clock_div;
        rd_mux[DIV_USB_LSB +: 4] = usb_div;
      end
      ADDR_STATUS: begin
        rd_mux[ST_LOCK] = pll_lock;
        rd_mux[ST_CONN] = pll_connected;
        rd_mux[ST_STATE_LSB +: 3] = state;
        rd_mux[ST_WSRC_LSB +: 2] = wake_src;
      end
      ADDR_RSTSRC: rd_mux[3:0] = rst_flags;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // zero-wait slave: read data latched at the address phase, always okay
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take & hwrite;
      if (take) begin
        wr_addr <= haddr[11:0];
      end
      if (take & ~hwrite) begin
        hrdata <= rd_mux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // chip reset has top priority, then automatic sleep clearing, then bus writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_sel <= SEL_IRC;
      pll_en <= 1'b0;
      pll_con <= 1'b0;
      pll_n <= PLL_N_RST;
      pll_m <= PLL_M_RST;
      processor_clock_div <= 8'h00;
      usb_div <= 4'h0;
      mode_req <= 1'b0;
      mode_val <= 2'h0;
    end else if (state == ST_RST) begin
      // defaults restored while reset is held
      // pll off and bypassed after reset
      clk_sel <= SEL_IRC;
      pll_en <= 1'b0;
      pll_con <= 1'b0;
      pll_n <= PLL_N_RST;
      pll_m <= PLL_M_RST;
      processor_clock_div <= 8'h00;
      usb_div <= 4'h0;
      mode_req <= 1'b0;
      mode_val <= 2'h0;
    end else begin
      mode_req <= 1'b0;
      if (enter_low) begin
        // pll off and disconnected on entry
        pll_en <= 1'b0;
        pll_con <= 1'b0;
        processor_clock_div <= 8'h00;
        usb_div <= 4'h0;
        // power-down wakes on the rc oscillator
        if (enter_pd) begin
          clk_sel <= SEL_IRC;
        end
      end else if (wr_pend) begin
        case (wr_addr)
          ADDR_CTRL: begin
            clk_sel <= hwdata[CTRL_SEL_LSB +: 2];
            pll_en <= hwdata[CTRL_PLLE];
            // connection taken only from software once locked
            pll_con <= hwdata[CTRL_PLLC] & hwdata[CTRL_PLLE] & (pll_con | (pll_en & pll_lock));
            mode_req <= hwdata[CTRL_MODE_LSB +: 2] != 2'h0;
            mode_val <= hwdata[CTRL_MODE_LSB +: 2];
          end
          ADDR_PLLCFG: begin
            pll_n <= hwdata[PLL_N_LSB +: 8];
            pll_m <= hwdata[PLL_M_LSB +: 15];
          end
          ADDR_DIV: begin
            processor_clock_div <= hwdata[DIV_PROCESSOR_CLOCK_LSB +: 8];
            usb_div <= hwdata[DIV_USB_LSB +: 4];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // sticky reset causes, write one to clear; a new cause wins over the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_flags <= 4'h0;
    end else begin
      rst_flags <= (rst_flags & ~((wr_pend && wr_addr == ADDR_RSTSRC) ? hwdata[3:0] : 4'h0))
                   | {~s2[2], s2[5], s2[4], s2[3]};
    end
  end

  // ----------------------------------------------------------------
  // pll dividers, phase-frequency compare and lock
  // ----------------------------------------------------------------
  logic [7:0] ncnt;    // pre-divider count
  logic [14:0] mcnt;   // feedback count
  logic ref_tick;      // divided input period
  logic fb_tick;       // divided cco period
  logic [1:0] fbn;     // feedback ticks since last reference tick
  logic [3:0] lockc;   // matched periods in a row
  assign ref_tick = pll_en & sel_rise & (ncnt == pll_n);
  assign fb_tick = pll_en & osc_rise.current_controlled_oscillator & (mcnt == pll_m);
  assign pll_lock = lockc == 4'(LOCK_REFS);

  // divider counters; held clear while the pll is off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ncnt <= 8'h00;
      mcnt <= 15'h0000;
    end else if (!pll_en) begin
      ncnt <= 8'h00;
      mcnt <= 15'h0000;
    end else begin
      if (sel_rise) begin
        ncnt <= ref_tick ? 8'h00 : ncnt + 8'h01;
      end
      if (osc_rise.current_controlled_oscillator) begin
        mcnt <= fb_tick ? 15'h0000 : mcnt + 15'h0001;
      end
    end
  end

  // compare steers the cco: up while reference leads, down while feedback leads
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cco_up <= 1'b0;
      cco_dn <= 1'b0;
      fbn <= 2'h0;
      lockc <= 4'h0;
    end else if (!pll_en) begin
      cco_up <= 1'b0;
      cco_dn <= 1'b0;
      fbn <= 2'h0;
      lockc <= 4'h0;
    end else begin
      cco_up <= ref_tick ? ~fb_tick : (cco_up & ~fb_tick);
      cco_dn <= fb_tick ? ~ref_tick : (cco_dn & ~ref_tick);
      if (ref_tick) begin
        // exactly one feedback period per reference period counts as matched
        fbn <= 2'h0;
        if ((fbn + {1'b0, fb_tick}) == 2'h1) begin
          lockc <= pll_lock ? lockc : lockc + 4'h1;
        end else begin
          lockc <= 4'h0;
        end
      end else if (fb_tick && fbn != 2'h3) begin
        fbn <= fbn + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power-mode and reset sequencer
  // ----------------------------------------------------------------
  logic wake_rise;        // cycle of the oscillator counted on wake
  logic [13:0] wake_last; // final count of the wake wait
  always_comb begin
    case (wake_src)
      SEL_MAIN: begin
        wake_rise = osc_rise.main_osc;
        wake_last = 14'(WAKE_MAIN_CYCLES - 1);
      end
      SEL_RTC: begin
        wake_rise = osc_rise.rtc;
        wake_last = 14'(WAKE_RTC_CYC - 1);
      end
      default: begin
        wake_rise = osc_rise.internal_rc_oscillator;
        wake_last = 14'(WAKE_IRC_CYC - 1);
      end
    endcase
  end

  // one counter, restarted at each reset or wake event
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_RST;
      cnt <= 14'h0000;
      wake_src <= SEL_IRC;
    end else if (any_rst) begin
      state <= ST_RST;
      cnt <= 14'h0000;
    end else begin
      case (state)
        ST_RST: begin
          // release after a fixed number of rc cycles once the pin is free
          if (osc_rise.internal_rc_oscillator) begin
            if (cnt == 14'(RST_OSC_CYCLES - 1)) begin
              state <= ST_RUN;
              cnt <= 14'h0000;
            end else begin
              cnt <= cnt + 14'h0001;
            end
          end
        end
        ST_RUN: begin
          cnt <= 14'h0000;
          if (mode_req) begin
            wake_src <= clk_sel;
            case (mode_val)
              MODE_IDLE: state <= ST_IDLE;
              MODE_SLEEP: state <= ST_SLEEP;
              default: state <= ST_PDOWN;
            endcase
          end
        end
        ST_IDLE: begin
          if (irq_s | cl_wake_s) begin
            state <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          // only a clockless interrupt or a reset ends sleep
          if (cl_wake_s) begin
            state <= ST_WCNT;
          end
        end
        ST_PDOWN: begin
          // wake from power-down always goes through the wake timer
          if (cl_wake_s) begin
            state <= (wake_src == SEL_IRC) ? ST_WSTART : ST_WCNT;
          end
        end
        ST_WSTART: begin
          // rc start-up time in system clocks
          if (cnt == 14'(IRC_START_CYCLES - 1)) begin
            state <= ST_WCNT;
            cnt <= 14'h0000;
          end else begin
            cnt <= cnt + 14'h0001;
          end
        end
        ST_WCNT: begin
          // count cycles of the prior source
          if (wake_rise) begin
            if (cnt == wake_last) begin
              state <= ST_RUN;
              cnt <= 14'h0000;
            end else begin
              cnt <= cnt + 14'h0001;
            end
          end
        end
        default: begin
          state <= ST_RST;
          cnt <= 14'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered mode outputs
  // ----------------------------------------------------------------
  // outputs lag the state by one cycle so every pin comes from a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_stall <= 1'b1;
      chip_rst <= 1'b1;
      periph_clk_en <= 1'b0;
      main_osc_en <= 1'b1;
      irc_power_en <= 1'b1;
      irc_out_en <= 1'b1;
      rtc_osc_en <= 1'b1;
      pins_hold <= 1'b0;
      pll_bypass <= 1'b1;
    end else begin
      // idle stalls the cpu but keeps peripheral clocks
      cpu_stall <= state != ST_RUN;
      chip_rst <= state == ST_RST;
      periph_clk_en <= (state == ST_RUN) | (state == ST_IDLE);
      // crystal stopped and pins frozen while asleep
      main_osc_en <= (state != ST_SLEEP) & (state != ST_PDOWN);
      pins_hold <= low_pwr;
      // rc output gated in sleep, power kept
      irc_out_en <= (state != ST_SLEEP) & (state != ST_PDOWN);
      irc_power_en <= state != ST_PDOWN;
      // 32 khz oscillator never stopped here
      rtc_osc_en <= 1'b1;
      // bypassed unless connected; the reset hold forces it on the same edge that pll_en clears
      pll_bypass <= ~pll_connected | (state == ST_RST);
    end
  end

  // ----------------------------------------------------------------
  // processor and usb clocks
  // ----------------------------------------------------------------
  logic [7:0] ccnt;  // processor divider count
  logic [3:0] ucnt;  // usb divider count
  logic pll_tgl;     // divided cco for the processor
  logic usb_tgl;     // divided cco for usb
  logic sel_lvl;     // level of the selected input
  assign sel_lvl = (clk_sel == SEL_MAIN) ? osc_s.main_osc : ((clk_sel == SEL_RTC) ? osc_s.rtc : osc_s.internal_rc_oscillator);

  // a divider value d toggles every d+1 cco cycles; limited to cco rates below clk/2
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ccnt <= 8'h00;
      ucnt <= 4'h0;
      pll_tgl <= 1'b0;
      usb_tgl <= 1'b0;
    end else if (osc_rise.current_controlled_oscillator) begin
      ccnt <= (ccnt >= processor_clock_div) ? 8'h00 : ccnt + 8'h01;
      pll_tgl <= (ccnt >= processor_clock_div) ? ~pll_tgl : pll_tgl;
      ucnt <= (ucnt >= usb_div) ? 4'h0 : ucnt + 4'h1;
      usb_tgl <= (ucnt >= usb_div) ? ~usb_tgl : usb_tgl;
    end
  end

  // input clock reaches processor_clock unless the pll is connected; usb_clock runs only while connected
  // all internal clocks gated in the low-power states
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      processor_clock <= 1'b0;
      usb_clock <= 1'b0;
    end else begin
      processor_clock <= ~low_pwr & (pll_connected ? pll_tgl : sel_lvl);
      usb_clock <= ~low_pwr & pll_connected & usb_tgl;
    end
  end
endmodule // cpmrc_ctrl

/* cpmrc_props.sv */
// checker for the clock, power-mode and reset controller outputs
// assumes it is bound onto cpmrc_ctrl with one clock domain
`timescale 1ns/10ps
module cpmrc_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic periph_clk_en,
  input wire logic cpu_stall,
  input wire logic chip_rst,
  input wire logic main_osc_en,
  input wire logic irc_power_en,
  input wire logic irc_out_en,
  input wire logic rtc_osc_en,
  input wire logic pins_hold,
  input wire logic pll_bypass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  // two cycles with the rc output gated: low-power state settled
  sequence s_gated; !irc_out_en ##1 !irc_out_en; endsequence
  property p_bus; hreadyout && !hresp; endproperty
  property p_rst; chip_rst |-> cpu_stall && pll_bypass; endproperty
  property p_rel; $fell(chip_rst) |-> !cpu_stall; endproperty
  property p_idle; periph_clk_en && cpu_stall |-> main_osc_en && irc_out_en; endproperty
  property p_slp; !main_osc_en |-> !irc_out_en && pins_hold && !periph_clk_en && cpu_stall; endproperty
  property p_pdn; !irc_power_en |-> !main_osc_en; endproperty
  property p_rtc; rtc_osc_en; endproperty
  property p_pll; s_gated |-> pll_bypass; endproperty
  property p_run; !cpu_stall |-> !pins_hold && !chip_rst; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
  a_rst: assert property (p_rst) else $error("reset hold without stall or bypass");
  a_rel: assert property (p_rel) else $error("stall outlives reset hold");
  a_idle: assert property (p_idle) else $error("idle stopped a clock");
  a_slp: assert property (p_slp) else $error("sleep outputs wrong");
  a_pdn: assert property (p_pdn) else $error("rc off while crystal on");
  a_rtc: assert property (p_rtc) else $error("32 khz oscillator stopped");
  a_pll: assert property (p_pll) else $error("pll connected in low power");
  a_run: assert property (p_run) else $error("running with pins held");
endmodule // cpmrc_props
bind cpmrc_ctrl cpmrc_props i_cpmrc_props (.clk(clk), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
  .periph_clk_en(periph_clk_en), .cpu_stall(cpu_stall), .chip_rst(chip_rst), .main_osc_en(main_osc_en),
  .irc_power_en(irc_power_en), .irc_out_en(irc_out_en), .rtc_osc_en(rtc_osc_en), .pins_hold(pins_hold),
  .pll_bypass(pll_bypass));

/* cpmrc_osc_model.sv */
// oscillator cells feeding the controller
// assumes enables from cpmrc_ctrl; rates kept far below clk/2
`timescale 1ns/10ps
module cpmrc_osc_model
  import cpmrc_pkg::*;
(
  input wire logic main_osc_en,
  input wire logic irc_power_en,
  output cpmrc_osc_t osc
);
  // every cell starts low; a stopped cell rests at 0
  initial osc = '0;
  always #25 osc.internal_rc_oscillator = irc_power_en ? ~osc.internal_rc_oscillator : 1'b0;
  always #35 osc.main_osc = main_osc_en ? ~osc.main_osc : 1'b0;
  always #45 osc.rtc = ~osc.rtc;
  always #15 osc.current_controlled_oscillator = ~osc.current_controlled_oscillator;
endmodule // cpmrc_osc_model

/* tb_top.sv */
// self-checking bench for cpmrc_ctrl over ahb-lite
// assumes the oscillator model drives osc_in
`timescale 1ns/10ps
module tb_top;
  import cpmrc_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d, m, e;} cpmrc_row_t;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, ext_rst_n = 1, irq_wake = 0, clockless_wake = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  cpmrc_rsrc_t rst_src = '0;
  cpmrc_osc_t osc_in;
  logic hreadyout, hresp, processor_clock, usb_clock, periph_clk_en, cpu_stall, chip_rst, main_osc_en;
  logic irc_power_en, irc_out_en, rtc_osc_en, pins_hold, pll_bypass, cco_up, cco_dn;
  int mismatches = 0, checks = 0, cyc = 0;
  // write then read back, masked
  cpmrc_row_t rows [6] = '{'{ADDR_CTRL, 32'h1, 32'h3f, 32'h1}, '{ADDR_CTRL, 32'h0, 32'h3f, 32'h0},
    '{ADDR_CTRL, 32'h2, 32'h3f, 32'h2},
    '{ADDR_PLLCFG, '1, 32'h7fffff, 32'h7fffff}, '{ADDR_DIV, '1, 32'hfff, 32'hfff}, '{12'h020, '1, '1, 32'h0}};
  // short counts keep the wake and reset waits brief
  cpmrc_ctrl #(.IRC_START_CYCLES(20), .WAKE_MAIN_CYCLES(8), .RST_OSC_CYCLES(4)) i_cpmrc_ctrl (
    .hready(hreadyout), .hsize(3'h2), .*);
  cpmrc_osc_model i_cpmrc_osc_model (.main_osc_en(main_osc_en), .irc_power_en(irc_power_en), .osc(osc_in));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single ahb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // the global timeout bounds these waits
  task automatic until_run;
    while (cpu_stall !== 1'b0) @(posedge clk);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // clock and hang guard
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up;
    end
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    while (chip_rst !== 1'b0) @(posedge clk);
    xfer(0, ADDR_PLLCFG, 0);
    chk(rd, 0);
    xfer(0, ADDR_STATUS, 0);
    chk(rd & 32'h1c, 32'h4);
    foreach (rows[i]) begin
      xfer(1, rows[i].a, rows[i].d);
      xfer(0, rows[i].a, 0);
      chk(rd & rows[i].m, rows[i].e);
    end
    xfer(1, ADDR_CTRL, 32'hc);
    xfer(0, ADDR_CTRL, 0);
    chk(rd & 32'hf, 32'h4);
    chk({31'h0, pll_bypass}, 1);
    xfer(1, ADDR_CTRL, 32'h20);
    irq_wake <= 1'b1;
    repeat (10) @(posedge clk);
    chk({26'h0, processor_clock, usb_clock, cpu_stall, main_osc_en, irc_out_en, irc_power_en}, 32'h9);
    irq_wake <= 1'b0;
    clockless_wake <= 1'b1;
    until_run;
    clockless_wake <= 1'b0;
    xfer(0, ADDR_DIV, 0);
    chk(rd, 0);
    // power-down from the rc and from the crystal
    for (int i = 0; i < 2; i++) begin
      xfer(1, ADDR_CTRL, 32'h30 | i);
      repeat (4) @(posedge clk);
      chk({31'h0, irc_power_en}, 0);
      clockless_wake <= 1'b1;
      until_run;
      clockless_wake <= 1'b0;
      xfer(0, ADDR_CTRL, 0);
      chk(rd & 32'h3, 0);
    end
    xfer(1, ADDR_CTRL, 32'h10);
    repeat (4) @(posedge clk);
    chk({30'h0, cpu_stall, periph_clk_en}, 3);
    irq_wake <= 1'b1;
    until_run;
    irq_wake <= 1'b0;
    // each reset cause in turn: bod, por, wdt, pin
    for (int i = 0; i < 4; i++) begin
      xfer(1, ADDR_RSTSRC, 32'hf);
      if (i < 3)
        rst_src <= 3'h1 << i;
      else
        ext_rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk({29'h0, cco_up, cco_dn, chip_rst}, 1);
      rst_src <= '0;
      ext_rst_n <= 1'b1;
      while (chip_rst !== 1'b0) @(posedge clk);
      xfer(0, ADDR_RSTSRC, 0);
      chk(rd & 32'hf, 32'h1 << i);
    end
    xfer(0, ADDR_PLLCFG, 0);
    chk(rd, 0);
    wrap_up;
  end
endmodule // tb_top
